// ---- rtl/dtd_core.sv ----
// Multi-channel tapped-chain time digitiser with windowed readout
// How it works
// - Per channel: interpolator, encoder, FIFO; one coarse counter shared by all channels
// - Each hit stores fine code with coarse stamp
// - Hit edge runs chain; taps latched, position gives fine
// - Stop is next rising clock edge after hit
// - Chain longer than period; edge always inside chain
// - Trigger type 0xd floods channels from oscillator
// - No leftover calibration hits in next physics event
// - Forward only hits inside window around reference edge; calibration readouts forward all hits
// - Pre and post window widths are programmable
// - Triggered mode clears epoch and coarse after window
// - Trigger-less mode: counters free-run and wrap
// - Newer releases ignore the trigger mode selection
// - Stream has header, epoch and data word kinds; debug kind is defined but never sent
// - Data word: marker, channel, fine, edge, coarse
// - Hit without valid fine carries dummy 0x3ff
`timescale 1ns/1ps
module dtd_core
	import dtd_pkg::*;
#(
	parameter int NUM_CH = 4,
	parameter int TAPS = 64,
	parameter int DEPTH = 8,
	parameter int WIN_W = 10,
	parameter bit HONOR_MODE = 1'b0
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [NUM_CH*TAPS-1:0] hit_taps,
	input wire logic reference_time_input,
	input wire logic trig_valid,
	input wire logic [3:0] trig_type,
	input wire logic [WIN_W-1:0] pre_win,
	input wire logic [WIN_W-1:0] post_win,
	input wire logic trig_mode,
	output logic cal_sel,
	output logic out_valid,
	output logic [WORD_W-1:0] out_data,
	input wire logic out_ready
);
	localparam int PW = $clog2(DEPTH);
	localparam int EW = COARSE_W + FINE_W;
	localparam int GW = $clog2(GUARD_CYC + 1);
	localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;

	dtd_strm_if #(.W(WORD_W)) bif ();
	dtd_state_t state_q;
	logic [COARSE_W-1:0] coarse_q;
	logic [COARSE_W-1:0] ref_coarse_q;
	logic [EPOCH_W-1:0] epoch_q;
	logic [EPOCH_W-1:0] ref_epoch_q;
	logic [TAPS-1:0] tq [NUM_CH];
	logic [NUM_CH-1:0] lead_q;
	logic [EW-1:0] mem [NUM_CH][DEPTH];
	logic [PW-1:0] wp_q [NUM_CH];
	logic [PW-1:0] rp_q [NUM_CH];
	logic [PW:0] cnt_q [NUM_CH];
	logic [NUM_CH-1:0] hit;
	logic [NUM_CH-1:0] wr;
	logic [FINE_W-1:0] fine [NUM_CH];
	logic ref_q;
	logic cal_q;
	logic is_cal_q;
	logic ovf_q;
	logic ed_q;
	logic [GW-1:0] guard_q;
	logic [WIN_W:0] wcnt_q;
	logic [CW-1:0] ch_q;
	logic wv_q;
	logic [WORD_W-1:0] wd_q;
	logic ref_edge;
	logic can_load;
	logic pop;
	logic flush;
	logic eff_mode;
	logic [EW-1:0] head;
	logic signed [COARSE_W:0] dd;
	logic early;
	logic late;

	// Count of ones in the latched taps
	function automatic logic [FINE_W-1:0] ones(input logic [TAPS-1:0] t);
		logic [FINE_W-1:0] n;
		n = '0;
		for (int i = 0; i < TAPS; i++)
			n = n + {{(FINE_W-1){1'b0}}, t[i]};
		return n;
	endfunction

	assign eff_mode = HONOR_MODE && trig_mode;
	assign ref_edge = reference_time_input && !ref_q;
	assign can_load = !wv_q || bif.ready;
	assign flush = state_q == DTD_DONE && is_cal_q;

	// Edge detect and encoder per channel
	for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
		wire logic [TAPS-1:0] t = tq[c];
		wire logic therm = ((t & (t + 1'b1)) == '0) && !(&t);
		assign hit[c] = t[0] && !lead_q[c];
		assign fine[c] = therm ? ones(t) : FINE_DUMMY;
		assign wr[c] = hit[c] && guard_q == '0 && !flush;
	end

	// Head of the channel under scan and its window position
	assign head = mem[ch_q][rp_q[ch_q]];
	assign dd = $signed({1'b0, head[COARSE_W-1:0]})
		- $signed({1'b0, ref_coarse_q});
	assign early = !is_cal_q && dd < -$signed({2'b0, pre_win});
	assign late = !is_cal_q && dd > $signed({2'b0, post_win});
	assign pop = state_q == DTD_SCAN && cnt_q[ch_q] != '0 && !late
		&& (early || can_load);

	// Taps latched at each rising clock edge
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lead_q <= '0;
			ref_q <= 1'b0;
			for (int c = 0; c < NUM_CH; c++)
				tq[c] <= '0;
		end else begin
			ref_q <= reference_time_input;
			for (int c = 0; c < NUM_CH; c++) begin
				tq[c] <= hit_taps[c*TAPS +: TAPS];
				lead_q[c] <= tq[c][0];
			end
		end
	end

	// Coarse and epoch counters
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			coarse_q <= '0;
			epoch_q <= '0;
		end else if (state_q == DTD_DONE && eff_mode) begin
			coarse_q <= '0;
			epoch_q <= '0;
		end else begin
			coarse_q <= coarse_q + 1'b1;
			if (&coarse_q)
				epoch_q <= epoch_q + 1'b1;
		end
	end

	// Channel FIFO storage, arrival order kept
	always_ff @(posedge clk) begin
		for (int c = 0; c < NUM_CH; c++)
			if (wr[c] && cnt_q[c] != DEPTH[PW:0])
				mem[c][wp_q[c]] <= {fine[c], coarse_q};
	end

	// FIFO pointers and overflow flag
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ovf_q <= 1'b0;
			for (int c = 0; c < NUM_CH; c++) begin
				wp_q[c] <= '0;
				rp_q[c] <= '0;
				cnt_q[c] <= '0;
			end
		end else begin
			if (state_q == DTD_HDR && can_load)
				ovf_q <= 1'b0;
			for (int c = 0; c < NUM_CH; c++) begin
				automatic logic w = wr[c] && cnt_q[c] != DEPTH[PW:0];
				automatic logic r = pop && ch_q == CW'(c);
				if (wr[c] && !w)
					ovf_q <= 1'b1;
				if (flush) begin
					wp_q[c] <= '0;
					rp_q[c] <= '0;
					cnt_q[c] <= '0;
				end else begin
					if (w)
						wp_q[c] <= wp_q[c] + 1'b1;
					if (r)
						rp_q[c] <= rp_q[c] + 1'b1;
					cnt_q[c] <= cnt_q[c] + {{PW{1'b0}}, w}
						- {{PW{1'b0}}, r};
				end
			end
		end
	end

	// Calibration request and post-flush guard
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cal_q <= 1'b0;
			cal_sel <= 1'b0;
			guard_q <= '0;
		end else begin
			if (trig_valid && trig_type == TRIG_CAL)
				cal_q <= 1'b1;
			else if (flush)
				cal_q <= 1'b0;
			cal_sel <= (trig_valid && trig_type == TRIG_CAL)
				|| (cal_q && !flush);
			if (flush)
				guard_q <= GW'(GUARD_CYC);
			else if (guard_q != '0)
				guard_q <= guard_q - 1'b1;
		end
	end

	// Readout sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= DTD_IDLE;
			ref_coarse_q <= '0;
			ref_epoch_q <= '0;
			is_cal_q <= 1'b0;
			wcnt_q <= '0;
			ch_q <= '0;
		end else begin
			unique case (state_q)
				DTD_IDLE: if (ref_edge) begin
					ref_coarse_q <= coarse_q;
					ref_epoch_q <= epoch_q;
					is_cal_q <= cal_q;
					wcnt_q <= '0;
					state_q <= DTD_POST;
				end
				DTD_POST: begin
					wcnt_q <= wcnt_q + 1'b1;
					if (wcnt_q >= {1'b0, post_win})
						state_q <= DTD_HDR;
				end
				DTD_HDR: if (can_load)
					state_q <= DTD_EPOCH;
				DTD_EPOCH: if (can_load) begin
					ch_q <= '0;
					state_q <= DTD_SCAN;
				end
				DTD_SCAN: if (cnt_q[ch_q] == '0 || late) begin
					if (ch_q == CW'(NUM_CH - 1))
						state_q <= DTD_DONE;
					else
						ch_q <= ch_q + 1'b1;
				end
				DTD_DONE: state_q <= DTD_IDLE;
			endcase
		end
	end

	// Word register feeding the output buffer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wv_q <= 1'b0;
			wd_q <= '0;
			ed_q <= 1'b0;
		end else if (can_load) begin
			wv_q <= 1'b0;
			ed_q <= 1'b0;
			if (state_q == DTD_HDR) begin
				wv_q <= 1'b1;
				wd_q <= {KIND_HDR, 1'b0, HDR_FORMAT, 8'h00, 15'h0000, ovf_q};
			end else if (state_q == DTD_EPOCH) begin
				wv_q <= 1'b1;
				wd_q <= {KIND_EPOCH, 1'b0, ref_epoch_q};
			end else if (pop && !early) begin
				wv_q <= 1'b1;
				ed_q <= 1'b1;
				wd_q <= {1'b1, 2'b00, CH_W'(ch_q), head[EW-1:COARSE_W],
					1'b1, head[COARSE_W-1:0]};
			end
		end
	end

	assign bif.valid = wv_q;
	assign bif.data = wd_q;

	dtd_skid #(.W(WORD_W)) u_skid (
		.clk(clk),
		.arst_n(arst_n),
		.up(bif),
		.out_valid(out_valid),
		.out_data(out_data),
		.out_ready(out_ready)
	);

	// Checks
	sequence s_ref_idle;
		state_q == DTD_IDLE && ref_edge;
	endsequence
	sequence s_post_open;
		state_q == DTD_POST && wcnt_q == '0;
	endsequence

	property p_coarse_run;
		@(posedge clk) disable iff (!arst_n)
		!(state_q == DTD_DONE && eff_mode)
			|=> coarse_q == $past(coarse_q) + 1'b1;
	endproperty
	a_coarse_run: assert property (p_coarse_run)
		else $error("coarse counter did not advance");

	property p_clear;
		@(posedge clk) disable iff (!arst_n)
		state_q == DTD_DONE && eff_mode |=> coarse_q == '0 && epoch_q == '0;
	endproperty
	a_clear: assert property (p_clear)
		else $error("counters not cleared after window");

	property p_post;
		@(posedge clk) disable iff (!arst_n)
		s_ref_idle |=> s_post_open;
	endproperty
	a_post: assert property (p_post)
		else $error("post window did not open on reference edge");

	property p_post_len;
		@(posedge clk) disable iff (!arst_n)
		state_q == DTD_POST |-> wcnt_q <= {1'b0, post_win};
	endproperty
	a_post_len: assert property (p_post_len)
		else $error("post window overran");

	property p_mark;
		@(posedge clk) disable iff (!arst_n)
		wv_q && ed_q |-> wd_q[DATA_MARK_BIT] && wd_q[EDGE_BIT]
			&& wd_q[30:29] == 2'b00;
	endproperty
	a_mark: assert property (p_mark)
		else $error("data word fields wrong");

	property p_dummy;
		@(posedge clk) disable iff (!arst_n)
		hit[0] && &tq[0] |-> fine[0] == FINE_DUMMY;
	endproperty
	a_dummy: assert property (p_dummy)
		else $error("overrun chain without dummy fine");

	property p_cal;
		@(posedge clk) disable iff (!arst_n)
		trig_valid && trig_type == TRIG_CAL |=> cal_sel && cal_q;
	endproperty
	a_cal: assert property (p_cal)
		else $error("calibration source not selected");

	property p_guard;
		@(posedge clk) disable iff (!arst_n)
		flush |=> guard_q != '0 && wr == '0 && cnt_q[0] == '0;
	endproperty
	a_guard: assert property (p_guard)
		else $error("calibration hits leaked past flush");

	property p_fifo;
		@(posedge clk) disable iff (!arst_n)
		cnt_q[0] <= DEPTH[PW:0];
	endproperty
	a_fifo: assert property (p_fifo)
		else $error("channel fifo count out of range");
endmodule

// ---- rtl/dtd_pkg.sv ----
// Shared constants for the delay-line time digitiser
package dtd_pkg;
	localparam int COARSE_W = 11;
	localparam int FINE_W = 10;
	localparam int EPOCH_W = 28;
	localparam int CH_W = 7;
	localparam int WORD_W = 32;
	localparam int COARSE_NS = 5;
	localparam logic [FINE_W-1:0] FINE_DUMMY = 10'h3ff;
	localparam logic [3:0] TRIG_CAL = 4'hd;
	localparam int DATA_MARK_BIT = 31;
	localparam int CH_LSB = 22;
	localparam int FINE_LSB = 12;
	localparam int EDGE_BIT = 11;
	localparam logic [2:0] KIND_HDR = 3'h1;
	localparam logic [2:0] KIND_DBG = 3'h2;
	localparam logic [2:0] KIND_EPOCH = 3'h3;
	localparam logic [3:0] HDR_FORMAT = 4'h0;
	localparam int GUARD_CYC = 16;
	typedef enum logic [2:0] {
		DTD_IDLE, DTD_POST, DTD_HDR, DTD_EPOCH, DTD_SCAN, DTD_DONE
	} dtd_state_t;
endpackage

// ---- rtl/dtd_strm_if.sv ----
// Word stream carrier between the capture core and its output buffer
`timescale 1ns/1ps
interface dtd_strm_if #(parameter int W = 32);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// ---- rtl/dtd_skid.sv ----
// Two-entry output buffer with registered outputs
`timescale 1ns/1ps
module dtd_skid
	import dtd_pkg::*;
#(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic arst_n,
	dtd_strm_if.snk up,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready
);
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	logic [W-1:0] tail_q;
	logic rdy_q;
	logic push;
	logic pop;

	// Handshakes on both sides
	assign push = up.valid && rdy_q;
	assign pop = out_valid && out_ready;
	assign up.ready = rdy_q;

	// Occupancy next value
	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop)
			cnt_d = cnt_q + 2'h1;
		else if (pop && !push)
			cnt_d = cnt_q - 2'h1;
	end

	// Occupancy and flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 2'h0;
			out_valid <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_valid <= cnt_d != 2'h0;
			rdy_q <= cnt_d != 2'h2;
		end
	end

	// Head and tail words
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_data <= '0;
			tail_q <= '0;
		end else begin
			if (pop && cnt_q == 2'h2)
				out_data <= tail_q;
			else if (push && (cnt_q == 2'h0 || (pop && cnt_q == 2'h1)))
				out_data <= up.data;
			if (push && (cnt_q == 2'h2 || (cnt_q == 2'h1 && !pop)))
				tail_q <= up.data;
		end
	end
endmodule

// ---- tb/dtd_ro_model.sv ----
// Readout-side partner that takes words with optional stalls
`timescale 1ns/1ps
module dtd_ro_model
	import dtd_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic slow,
	input wire logic out_valid,
	input wire logic [WORD_W-1:0] out_data,
	output logic out_ready
);
	logic [WORD_W-1:0] q[$];
	logic [1:0] ph;

	// Accept on handshake, then move ready just after the edge
	initial begin
		out_ready = 1'b0;
		ph = 2'h0;
		forever begin
			@(posedge clk);
			if (out_valid && out_ready) begin
				q.push_back(out_data);
			end
			#1;
			ph = ph + 2'h1;
			out_ready = arst_n && (!slow || ph == 2'h0);
		end
	end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the time digitiser core
`timescale 1ns/1ps
module testbench;
	import dtd_pkg::*;
	localparam int NCH = 4;
	localparam int TP = 64;
	logic clk;
	logic arst_n;
	logic [NCH*TP-1:0] hit_taps;
	logic ref_in;
	logic trig_valid;
	logic [3:0] trig_type;
	logic trig_mode;
	logic slow;
	logic cal_sel;
	logic out_valid;
	logic out_ready;
	logic [WORD_W-1:0] out_data;
	logic [9:0] pre_win;
	logic [9:0] post_win;
	logic tv;
	logic tr;
	logic [WORD_W-1:0] td;
	int fail_count = 0;
	int n_compared = 0;
	int cyc = 0;
	int t_hit;
	int t_a;
	logic [10:0] c_a;

	dtd_core u_dut (.clk(clk), .arst_n(arst_n), .hit_taps(hit_taps),
		.reference_time_input(ref_in), .trig_valid(trig_valid),
		.trig_type(trig_type), .pre_win(pre_win), .post_win(post_win),
		.trig_mode(trig_mode), .cal_sel(cal_sel), .out_valid(out_valid),
		.out_data(out_data), .out_ready(out_ready));

	dtd_ro_model u_ro (.clk(clk), .arst_n(arst_n), .slow(slow),
		.out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));

	// Second core that honours the triggered mode and clears its counters
	dtd_core #(.HONOR_MODE(1'b1)) u_trg (.clk(clk), .arst_n(arst_n),
		.hit_taps(hit_taps), .reference_time_input(ref_in),
		.trig_valid(trig_valid), .trig_type(trig_type), .pre_win(pre_win),
		.post_win(post_win), .trig_mode(trig_mode), .cal_sel(),
		.out_valid(tv), .out_data(td), .out_ready(tr));

	dtd_ro_model u_ro_t (.clk(clk), .arst_n(arst_n), .slow(slow),
		.out_valid(tv), .out_data(td), .out_ready(tr));

	// Clock at 8 ns
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Cycle count and hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			tally_and_finish();
		end
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// Upper part of a data word, rising edge
	function automatic logic [20:0] dhi(input int ch, input logic [9:0] f);
		return {1'b1, 2'b00, 7'(ch), f, 1'b1};
	endfunction

	// One hit: taps shown for a single sample
	task automatic hit(input int ch, input logic [TP-1:0] p);
		hit_taps[ch*TP+:TP] = p;
		tick(1);
		t_hit = cyc;
		hit_taps = '0;
		tick(1);
	endtask

	task automatic readout();
		ref_in = 1'b1;
		tick(2);
		ref_in = 1'b0;
	endtask

	// Wait for n words, bounded
	task automatic take(input int n);
		int k;
		k = 0;
		while (u_ro.q.size() < n && k < 500) begin
			tick(1);
			k++;
		end
		chk(u_ro.q.size(), n);
	endtask

	// Windowed readout under a stalling reader
	task automatic sc_window();
		int t0;
		hit(1, 64'h1);
		tick(100);
		readout();
		hit(0, 64'h1f);
		t0 = t_hit;
		hit(2, 64'h5);
		hit(0, '1);
		take(5);
		tick(40);
		chk(u_ro.q.size(), 5);
		chk(u_ro.q[0][31:29], KIND_HDR);
		chk(u_ro.q[0][0], 1'b0);
		chk(u_ro.q[1][31:29], KIND_EPOCH);
		chk(u_ro.q[2][31:11], dhi(0, 10'h005));
		chk(u_ro.q[3][31:11], dhi(0, FINE_DUMMY));
		chk(u_ro.q[4][31:11], dhi(2, FINE_DUMMY));
		chk(11'(u_ro.q[3][10:0] - u_ro.q[2][10:0]), 11'(t_hit - t0));
		c_a = u_ro.q[2][10:0];
		t_a = t0;
	endtask

	// Calibration readout, then a clean physics readout
	task automatic sc_cal();
		int k;
		u_ro.q.delete();
		u_ro_t.q.delete();
		trig_type = 4'h1;
		trig_valid = 1'b1;
		tick(1);
		trig_valid = 1'b0;
		tick(1);
		chk(cal_sel, 1'b0);
		trig_type = TRIG_CAL;
		trig_valid = 1'b1;
		tick(1);
		trig_valid = 1'b0;
		chk(cal_sel, 1'b1);
		hit(3, 64'h3);
		tick(100);
		readout();
		take(3);
		chk(u_ro.q[2][31:11], dhi(3, 10'h002));
		chk(u_ro_t.q[2][10:0] < 11'(t_hit - t_a), 1'b1);
		chk(11'(u_ro.q[2][10:0] - c_a), 11'(t_hit - t_a));
		hit(1, 64'h7);
		k = 0;
		while (cal_sel !== 1'b0 && k < 200) begin
			tick(1);
			k++;
		end
		chk(cal_sel, 1'b0);
		u_ro.q.delete();
		readout();
		take(2);
		tick(60);
		chk(u_ro.q.size(), 2);
	endtask

	// Narrow pre window and an overfilled channel
	task automatic sc_prog();
		u_ro.q.delete();
		pre_win = 10'h004;
		repeat (9) hit(2, 64'h3);
		tick(10);
		readout();
		take(2);
		tick(40);
		chk(u_ro.q.size(), 2);
		chk(u_ro.q[0][0], 1'b1);
	endtask

	task automatic tally_and_finish();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Reset, then the scenarios
	initial begin
		arst_n = 1'b0;
		hit_taps = '0;
		ref_in = 1'b0;
		trig_valid = 1'b0;
		trig_type = 4'h0;
		trig_mode = 1'b1;
		pre_win = 10'h040;
		post_win = 10'h014;
		slow = 1'b1;
		tick(10);
		arst_n = 1'b1;
		tick(2);
		sc_window();
		slow = 1'b0;
		sc_cal();
		sc_prog();
		tally_and_finish();
	end
endmodule
